// *** hw/msc_pkg.sv ***
// Package for the motion sensor configuration block: map, fields, timing
package msc_pkg;
   // Register offsets
   localparam logic [7:0] ADDR_RATE_DIV = 8'h19;
   localparam logic [7:0] ADDR_FILTER_SYNC = 8'h1A;
   localparam logic [7:0] ADDR_GYRO_CFG = 8'h1B;
   localparam logic [7:0] ADDR_ACCEL_CFG = 8'h1C;
   // Field positions
   localparam int SYNC_SEL_LSB = 3;
   localparam int LPF_LSB = 0;
   localparam int ST_X_BIT = 7;
   localparam int ST_Y_BIT = 6;
   localparam int ST_Z_BIT = 5;
   localparam int RANGE_LSB = 3;
   // Writable bit masks; reserved bits stay zero
   localparam logic [7:0] FILTER_SYNC_MASK = 8'h3F;
   localparam logic [7:0] RANGE_ST_MASK = 8'hF8;
   // Reset values
   localparam logic [7:0] RESET_CFG = 8'h00;
   // Sync select codes
   localparam logic [2:0] SYNC_OFF = 3'h0;
   localparam logic [2:0] SYNC_TEMP = 3'h1;
   // Low-pass settings
   localparam logic [2:0] LPF_WIDE = 3'h0;
   localparam logic [2:0] LPF_RESVD = 3'h7;
   // Timing: rates in Hz and clock
   localparam int CLK_HZ = 100_000_000;
   localparam int GYRO_FAST_HZ = 8000;
   localparam int GYRO_SLOW_HZ = 1000;
   localparam int ACCEL_HZ = 1000;
   localparam int FAST_TICK_CYC = CLK_HZ / GYRO_FAST_HZ;
   localparam int SLOW_TICK_CYC = CLK_HZ / GYRO_SLOW_HZ;
   localparam int ACCEL_TICK_CYC = CLK_HZ / ACCEL_HZ;
   // Grouped sensor configuration
   typedef struct packed {
      logic [2:0] gyro_selftest;   // X,Y,Z
      logic [1:0] gyro_range_select;
      logic [2:0] accel_selftest;  // X,Y,Z
      logic [1:0] accel_range_select;
      logic [2:0] lowpass_setting;
   } msc_cfg_t;
endpackage

// *** hw/msc_config.sv ***
// Motion sensor configuration registers, frame sync capture and rate ticks
//
// Decided for this implementation: the plain strobed port.

// Notes on behaviour
// - Frame sync pin changes are latched so short strobes are caught.
// - Latched frame sync is sampled once per sample-rate tick.
// - After sampling the latch reloads with present pin level, not zero.
// - Sampled bit goes to bit 0 of the low byte picked by sync select.
// - Sync select at bits 5:3, low-pass setting at bits 2:0, 7:6 reserved.
// - Gyro runs 8 kHz at settings 0 and 7, else 1 kHz; accel always 1 kHz.
// - Low-pass setting fixes bandwidth and delay of both sensors; 7 reserved.
// - Gyro self-test bits 7,6,5 actuate X,Y,Z axes, any combination.
// - Gyro range select at bits 4:3: 250, 500, 1000, 2000 deg/s.
// - Gyro config bits 2:0 are reserved and have no function.
// - Accel self-test bits 7,6,5 actuate X,Y,Z axes, any combination.
// - Accel range select at bits 4:3: 2, 4, 8, 16 g.
// - Sample tick is gyro rate divided by one plus the divider value.
module msc_config #(
   parameter int FAST_CYC = msc_pkg::FAST_TICK_CYC,
   parameter int SLOW_CYC = msc_pkg::SLOW_TICK_CYC,
   parameter int ACC_CYC = msc_pkg::ACCEL_TICK_CYC
) (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // Register port
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   // External frame sync pin
   input wire logic frame_sync_pin_i,
   // Sample-rate events and captured sync
   output logic sample_tick_o,
   output logic gyro_tick_o,
   output logic accel_tick_o,
   output logic sync_sample_o,
   // One-hot low byte target: temp, gx, gy, gz, ax, ay, az
   output logic [6:0] sync_target_o,
   // Analog front-end control
   output msc_pkg::msc_cfg_t cfg_o
);

   // Pin synchroniser
   logic sync_meta_r, sync_pin_r, sync_prev_r;
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         sync_meta_r <= 1'b0;
         sync_pin_r <= 1'b0;
         sync_prev_r <= 1'b0;
      end else begin
         sync_meta_r <= frame_sync_pin_i;
         sync_pin_r <= sync_meta_r;
         sync_prev_r <= sync_pin_r;
      end
   end

   // Register storage
   logic [7:0] div_r, div_nxt;
   logic [7:0] fs_r, fs_nxt;
   logic [7:0] gyro_r, gyro_nxt;
   logic [7:0] acc_r, acc_nxt;
   logic [7:0] rdata_r, rdata_nxt;

   // Writes mask reserved bits, so they read zero
   always_comb begin
      div_nxt = div_r;
      fs_nxt = fs_r;
      gyro_nxt = gyro_r;
      acc_nxt = acc_r;
      if (reg_wr_i) begin
         unique case (reg_addr_i)
            msc_pkg::ADDR_RATE_DIV: div_nxt = reg_wdata_i;
            msc_pkg::ADDR_FILTER_SYNC: fs_nxt = reg_wdata_i & msc_pkg::FILTER_SYNC_MASK;
            msc_pkg::ADDR_GYRO_CFG: gyro_nxt = reg_wdata_i & msc_pkg::RANGE_ST_MASK;
            msc_pkg::ADDR_ACCEL_CFG: acc_nxt = reg_wdata_i & msc_pkg::RANGE_ST_MASK;
            default: ;
         endcase
      end
   end

   // Read data stands one cycle after the strobe; unmapped reads zero
   always_comb begin
      rdata_nxt = 8'h00;
      if (reg_rd_i) begin
         unique case (reg_addr_i)
            msc_pkg::ADDR_RATE_DIV: rdata_nxt = div_r;
            msc_pkg::ADDR_FILTER_SYNC: rdata_nxt = fs_r;
            msc_pkg::ADDR_GYRO_CFG: rdata_nxt = gyro_r;
            msc_pkg::ADDR_ACCEL_CFG: rdata_nxt = acc_r;
            default: rdata_nxt = 8'h00;
         endcase
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         div_r <= msc_pkg::RESET_CFG;
         fs_r <= msc_pkg::RESET_CFG;
         gyro_r <= msc_pkg::RESET_CFG;
         acc_r <= msc_pkg::RESET_CFG;
         rdata_r <= 8'h00;
      end else begin
         div_r <= div_nxt;
         fs_r <= fs_nxt;
         gyro_r <= gyro_nxt;
         acc_r <= acc_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // Field views
   logic [2:0] sync_capture_select;
   logic [2:0] lowpass_setting;
   logic lpf_bypass;
   assign sync_capture_select = fs_r[msc_pkg::SYNC_SEL_LSB +: 3];
   assign lowpass_setting = fs_r[msc_pkg::LPF_LSB +: 3];
   // Reserved setting 7 runs the gyro like setting 0, as filter disabled
   assign lpf_bypass = (lowpass_setting == msc_pkg::LPF_WIDE) ||
                       (lowpass_setting == msc_pkg::LPF_RESVD);

   // Gyro and accel rate dividers as one-cycle enables
   // 32 bits, since the slow periods at full clock rate exceed 16 bits
   logic [31:0] gcnt_r, gcnt_nxt;
   logic [31:0] acnt_r, acnt_nxt;
   logic gtick_nxt, atick_nxt;
   logic [31:0] gyro_period;
   always_comb begin
      gyro_period = lpf_bypass ? 32'(FAST_CYC) : 32'(SLOW_CYC);
      gtick_nxt = 1'b0;
      atick_nxt = 1'b0;
      gcnt_nxt = gcnt_r + 32'h00000001;
      acnt_nxt = acnt_r + 32'h00000001;
      if (gcnt_r >= gyro_period - 32'h00000001) begin
         gcnt_nxt = 32'h00000000;
         gtick_nxt = 1'b1;
      end
      if (acnt_r >= 32'(ACC_CYC) - 32'h00000001) begin
         acnt_nxt = 32'h00000000;
         atick_nxt = 1'b1;
      end
   end

   // Sample tick: every (1 + divider) gyro ticks
   logic [7:0] scnt_r, scnt_nxt;
   logic stick_nxt;
   always_comb begin
      scnt_nxt = scnt_r;
      stick_nxt = 1'b0;
      if (gtick_nxt) begin
         if (scnt_r >= div_r) begin
            scnt_nxt = 8'h00;
            stick_nxt = 1'b1;
         end else begin
            scnt_nxt = scnt_r + 8'h01;
         end
      end
   end

   // Frame sync latch: edge catches, sample tick reloads with pin level
   logic latch_r, latch_nxt;
   logic sample_r, sample_nxt;
   logic [6:0] target_r, target_nxt;
   always_comb begin
      latch_nxt = latch_r | (sync_pin_r ^ sync_prev_r);
      sample_nxt = sample_r;
      if (stick_nxt) begin
         sample_nxt = latch_nxt;
         latch_nxt = sync_pin_r;
      end
      // Disabled select routes the bit nowhere
      target_nxt = 7'h00;
      if (sync_capture_select != msc_pkg::SYNC_OFF) begin
         target_nxt[sync_capture_select - msc_pkg::SYNC_TEMP] = 1'b1;
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         gcnt_r <= 32'h00000000;
         acnt_r <= 32'h00000000;
         scnt_r <= 8'h00;
         sample_tick_o <= 1'b0;
         gyro_tick_o <= 1'b0;
         accel_tick_o <= 1'b0;
         latch_r <= 1'b0;
         sample_r <= 1'b0;
         target_r <= 7'h00;
      end else begin
         gcnt_r <= gcnt_nxt;
         acnt_r <= acnt_nxt;
         scnt_r <= scnt_nxt;
         sample_tick_o <= stick_nxt;
         gyro_tick_o <= gtick_nxt;
         accel_tick_o <= atick_nxt;
         latch_r <= latch_nxt;
         sample_r <= sample_nxt;
         target_r <= target_nxt;
      end
   end

   // Front-end controls registered for clean analog drive
   msc_pkg::msc_cfg_t cfg_nxt;
   always_comb begin
      cfg_nxt.gyro_selftest = gyro_r[msc_pkg::ST_Z_BIT +: 3];
      cfg_nxt.gyro_range_select = gyro_r[msc_pkg::RANGE_LSB +: 2];
      cfg_nxt.accel_selftest = acc_r[msc_pkg::ST_Z_BIT +: 3];
      cfg_nxt.accel_range_select = acc_r[msc_pkg::RANGE_LSB +: 2];
      cfg_nxt.lowpass_setting = lowpass_setting;
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         cfg_o <= '0;
      end else begin
         cfg_o <= cfg_nxt;
      end
   end

   assign reg_rdata_o = rdata_r;
   assign sync_sample_o = sample_r;
   assign sync_target_o = target_r;

   // Assertion helpers: cycles since the last tick, and whether the filter
   // mode held still since then; counters saturate rather than wrap
   logic [31:0] ggap_r, ggap_nxt;
   logic [31:0] agap_r, agap_nxt;
   logic steady_r, steady_nxt;
   logic bypass_prev_r;
   always_comb begin
      ggap_nxt = (ggap_r == 32'hFFFFFFFF) ? ggap_r : ggap_r + 32'h00000001;
      agap_nxt = (agap_r == 32'hFFFFFFFF) ? agap_r : agap_r + 32'h00000001;
      steady_nxt = steady_r && (lpf_bypass == bypass_prev_r);
      if (gyro_tick_o) begin
         ggap_nxt = 32'h00000001;
         steady_nxt = 1'b1;
      end
      if (accel_tick_o) begin
         agap_nxt = 32'h00000001;
      end
   end

   // First gyro tick after reset is never judged: steady starts low
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ggap_r <= 32'h00000000;
         agap_r <= 32'h00000000;
         steady_r <= 1'b0;
         bypass_prev_r <= 1'b0;
      end else begin
         ggap_r <= ggap_nxt;
         agap_r <= agap_nxt;
         steady_r <= steady_nxt;
         bypass_prev_r <= lpf_bypass;
      end
   end

   // Assertions
   chk_reserved_zero: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (fs_r[7:6] == 2'b00) && (gyro_r[2:0] == 3'h0) && (acc_r[2:0] == 3'h0))
      else $error("reserved bits not zero");
   chk_read_latency: assert property (@(posedge core_clk_i) disable iff (rst_i)
      reg_rd_i && !reg_wr_i && reg_addr_i == msc_pkg::ADDR_GYRO_CFG
      |=> reg_rdata_o == $past(gyro_r))
      else $error("read data wrong");
   chk_frame_sync_pin_catch: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (sync_pin_r != sync_prev_r) && !stick_nxt |=> latch_r)
      else $error("sync edge lost");
   chk_frame_sync_pin_sample: assert property (@(posedge core_clk_i) disable iff (rst_i)
      stick_nxt |=> sync_sample_o == $past(latch_r | (sync_pin_r ^ sync_prev_r)))
      else $error("sync sample wrong");
   chk_frame_sync_pin_reload: assert property (@(posedge core_clk_i) disable iff (rst_i)
      stick_nxt |=> latch_r == $past(sync_pin_r))
      else $error("latch reload wrong");
   chk_target_route: assert property (@(posedge core_clk_i) disable iff (rst_i)
      sync_capture_select == msc_pkg::SYNC_OFF |=> sync_target_o == 7'h00)
      else $error("disabled sync routed");
   chk_gyro_fast: assert property (@(posedge core_clk_i) disable iff (rst_i)
      gyro_tick_o && steady_r && bypass_prev_r |-> ggap_r == 32'(FAST_CYC))
      else $error("gyro tick spacing");
   chk_gyro_slow: assert property (@(posedge core_clk_i) disable iff (rst_i)
      gyro_tick_o && steady_r && !bypass_prev_r |-> ggap_r == 32'(SLOW_CYC))
      else $error("slow gyro tick spacing");
   chk_accel_rate: assert property (@(posedge core_clk_i) disable iff (rst_i)
      accel_tick_o |-> agap_r == 32'(ACC_CYC))
      else $error("accel tick spacing");
   chk_gyro_range: assert property (@(posedge core_clk_i) disable iff (rst_i)
      1'b1 |=> cfg_o.gyro_range_select == $past(gyro_r[4:3]))
      else $error("gyro range wrong");
   chk_accel_st: assert property (@(posedge core_clk_i) disable iff (rst_i)
      1'b1 |=> cfg_o.accel_selftest == $past(acc_r[7:5]))
      else $error("accel selftest wrong");
   chk_gyro_st: assert property (@(posedge core_clk_i) disable iff (rst_i)
      1'b1 |=> cfg_o.gyro_selftest == $past(gyro_r[7:5]))
      else $error("gyro selftest wrong");
   chk_accel_range: assert property (@(posedge core_clk_i) disable iff (rst_i)
      1'b1 |=> cfg_o.accel_range_select == $past(acc_r[4:3]))
      else $error("accel range wrong");
   chk_sample_div: assert property (@(posedge core_clk_i) disable iff (rst_i)
      stick_nxt |-> gtick_nxt)
      else $error("sample tick off gyro tick");
   // Register writes keep only the writable fields
   chk_fs_write: assert property (@(posedge core_clk_i) disable iff (rst_i)
      reg_wr_i && reg_addr_i == msc_pkg::ADDR_FILTER_SYNC
      |=> fs_r[7:6] == 2'b00 && fs_r[5:0] == $past(reg_wdata_i[5:0]))
      else $error("filter sync write wrong");
   chk_gyro_write: assert property (@(posedge core_clk_i) disable iff (rst_i)
      reg_wr_i && reg_addr_i == msc_pkg::ADDR_GYRO_CFG
      |=> gyro_r[7:3] == $past(reg_wdata_i[7:3]))
      else $error("gyro config write wrong");
   chk_accel_write: assert property (@(posedge core_clk_i) disable iff (rst_i)
      reg_wr_i && reg_addr_i == msc_pkg::ADDR_ACCEL_CFG
      |=> acc_r[7:3] == $past(reg_wdata_i[7:3]))
      else $error("accel config write wrong");
   chk_rdata_idle: assert property (@(posedge core_clk_i) disable iff (rst_i)
      !reg_rd_i |=> reg_rdata_o == 8'h00)
      else $error("read data without strobe");
   chk_lpf_out: assert property (@(posedge core_clk_i) disable iff (rst_i)
      1'b1 |=> cfg_o.lowpass_setting == $past(fs_r[2:0]))
      else $error("lowpass setting wrong");
   chk_target_onehot: assert property (@(posedge core_clk_i) disable iff (rst_i)
      sync_capture_select != msc_pkg::SYNC_OFF
      |=> sync_target_o == (7'h01 << ($past(sync_capture_select) - 3'h1)))
      else $error("sync target wrong");
   chk_sample_pulse: assert property (@(posedge core_clk_i) disable iff (rst_i)
      sample_tick_o |=> !sample_tick_o)
      else $error("sample tick too long");
   chk_latch_hold: assert property (@(posedge core_clk_i) disable iff (rst_i)
      !stick_nxt && (sync_pin_r == sync_prev_r) |=> latch_r == $past(latch_r))
      else $error("latch moved without edge");

endmodule

// *** test/msc_sync_src.sv ***
// Frame sync source model: one-cycle strobes or a held level on the pin
module msc_sync_src (
   // Clock and commands from the bench
   input wire logic core_clk_i,
   input wire logic fire_i,
   input wire logic hold_i,
   // Frame sync pin
   output logic frame_sync_pin_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // Pin idles low until commanded
   initial frame_sync_pin_o = 1'b0;
   // Skewed off the edge, since the real pin is asynchronous
   always @(posedge core_clk_i) begin
      frame_sync_pin_o <= #3 hold_i | fire_i;
   end
endmodule

// *** test/tb_msc_config.sv ***
// Self-checking bench for the motion sensor configuration block
module tb_msc_config;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk_i, rst_i, reg_wr_i, reg_rd_i, fire, hold, pin;
   logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, lfsr, a, d;
   logic sample_tick_o, gyro_tick_o, accel_tick_o, sync_sample_o;
   logic [6:0] sync_target_o;
   msc_pkg::msc_cfg_t cfg_o;
   logic [7:0] shadow [4];
   int failures = 0;
   int check_count = 0;

   // Small counts keep the rate checks short
   msc_config #(.FAST_CYC(4), .SLOW_CYC(8), .ACC_CYC(8)) u_msc_config (
      .core_clk_i(core_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_rdata_o(reg_rdata_o), .frame_sync_pin_i(pin), .sample_tick_o(sample_tick_o),
      .gyro_tick_o(gyro_tick_o), .accel_tick_o(accel_tick_o),
      .sync_sample_o(sync_sample_o), .sync_target_o(sync_target_o), .cfg_o(cfg_o));
   msc_sync_src u_msc_sync_src (.core_clk_i(core_clk_i), .fire_i(fire), .hold_i(hold),
      .frame_sync_pin_o(pin));

   // Clock
   initial begin
      core_clk_i = 1'b0;
      forever #5 core_clk_i = ~core_clk_i;
   end

   function automatic logic [7:0] lfsr_next(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction
   // Writable bits; reserved and unmapped bits read zero
   function automatic logic [7:0] mask_of(input logic [7:0] adr);
      case (adr)
         msc_pkg::ADDR_RATE_DIV: return 8'hFF;
         msc_pkg::ADDR_FILTER_SYNC: return 8'h3F;
         msc_pkg::ADDR_GYRO_CFG, msc_pkg::ADDR_ACCEL_CFG: return 8'hF8;
         default: return 8'h00;
      endcase
   endfunction
   // Gyro period: fast when the filter is off (settings 0 and 7)
   function automatic int gyro_cyc(input logic [2:0] lp);
      return (lp == 3'h0 || lp == 3'h7) ? 4 : 8;
   endfunction
   function automatic logic tick(input int sel);
      return sel == 0 ? gyro_tick_o : (sel == 1 ? accel_tick_o : sample_tick_o);
   endfunction

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run();
      if (failures == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] adr, input logic [7:0] val);
      @(posedge core_clk_i);
      reg_addr_i <= adr;
      reg_wdata_i <= val;
      reg_wr_i <= 1'b1;
      @(posedge core_clk_i);
      reg_wr_i <= 1'b0;
      if (mask_of(adr) != 8'h00) shadow[2'(adr - 8'h19)] = val & mask_of(adr);
   endtask
   task automatic rd(input logic [7:0] adr);
      @(posedge core_clk_i);
      reg_addr_i <= adr;
      reg_rd_i <= 1'b1;
      @(posedge core_clk_i);
      reg_rd_i <= 1'b0;
      #1;
      check(16'(reg_rdata_o), 16'(mask_of(adr) != 8'h00 ? shadow[2'(adr - 8'h19)] : 8'h00));
   endtask
   // Bounded wait for the next pulse; returns cycles waited
   task automatic wait_tick(input int sel, output int n);
      n = 0;
      do begin
         @(posedge core_clk_i);
         #1;
         n++;
      end while (tick(sel) !== 1'b1 && n < 3000);
      if (n >= 3000) begin
         failures++;
         complete_run();
      end
   endtask
   // First two waits absorb a rate change in flight
   task automatic period(input int sel, input int exp);
      int n;
      wait_tick(sel, n);
      wait_tick(sel, n);
      wait_tick(sel, n);
      check(16'(n), 16'(exp));
   endtask

   initial begin
      int n;
      rst_i = 1'b1;
      reg_wr_i = 1'b0;
      reg_rd_i = 1'b0;
      reg_addr_i = 8'h00;
      reg_wdata_i = 8'h00;
      fire = 1'b0;
      hold = 1'b0;
      lfsr = 8'h31;
      for (int i = 0; i < 4; i++) shadow[i] = 8'h00;
      repeat (3) @(posedge core_clk_i);
      rst_i <= 1'b0;
      // Reset values
      for (int i = 0; i < 4; i++) rd(8'h19 + 8'(i));
      check(16'(cfg_o), 16'h0000);
      // Random writes and readbacks, unmapped places among them
      repeat (40) begin
         lfsr = lfsr_next(lfsr);
         a = lfsr[2] ? 8'h19 + {6'h0, lfsr[1:0]} : {3'h7, lfsr[4:0]};
         lfsr = lfsr_next(lfsr);
         d = lfsr;
         wr(a, d);
         rd(a);
         check(16'(cfg_o), 16'({shadow[2][7:5], shadow[2][4:3], shadow[3][7:5],
            shadow[3][4:3], shadow[1][2:0]}));
      end
      // Self-test on then off, as the host does to form its difference
      wr(msc_pkg::ADDR_GYRO_CFG, 8'hE0);
      wr(msc_pkg::ADDR_ACCEL_CFG, 8'hF0);
      @(posedge core_clk_i);
      #1;
      check(16'({cfg_o.gyro_selftest, cfg_o.accel_selftest}), 16'h003F);
      wr(msc_pkg::ADDR_GYRO_CFG, 8'h00);
      wr(msc_pkg::ADDR_ACCEL_CFG, 8'h00);
      @(posedge core_clk_i);
      #1;
      check(16'({cfg_o.gyro_selftest, cfg_o.accel_selftest}), 16'h0000);
      // Each sync select code 1 to 7 picks its own low byte; code 0 picks none
      for (int s = 0; s < 8; s++) begin
         wr(msc_pkg::ADDR_FILTER_SYNC, 8'(s << 3));
         @(posedge core_clk_i);
         #1;
         check(16'(sync_target_o), 16'(s == 0 ? 0 : 1 << (s - 1)));
      end
      // Output rates for every low-pass setting
      wr(msc_pkg::ADDR_RATE_DIV, 8'h00);
      for (int lp = 0; lp < 8; lp++) begin
         wr(msc_pkg::ADDR_FILTER_SYNC, 8'(lp));
         period(0, gyro_cyc(3'(lp)));
         period(1, 8);
         period(2, gyro_cyc(3'(lp)));
      end
      // Divided sample rate, top divider value too
      wr(msc_pkg::ADDR_FILTER_SYNC, 8'h01);
      wr(msc_pkg::ADDR_RATE_DIV, 8'h02);
      period(2, 24);
      wr(msc_pkg::ADDR_FILTER_SYNC, 8'h00);
      wr(msc_pkg::ADDR_RATE_DIV, 8'hFF);
      period(2, 1024);
      // One-cycle strobe caught, then the latch follows the pin level
      wr(msc_pkg::ADDR_RATE_DIV, 8'h03);
      wait_tick(2, n);
      wait_tick(2, n);
      @(posedge core_clk_i);
      fire <= 1'b1;
      @(posedge core_clk_i);
      fire <= 1'b0;
      wait_tick(2, n);
      check(16'(sync_sample_o), 16'h0001);
      wait_tick(2, n);
      check(16'(sync_sample_o), 16'h0000);
      @(posedge core_clk_i);
      hold <= 1'b1;
      wait_tick(2, n);
      wait_tick(2, n);
      check(16'(sync_sample_o), 16'h0001);
      complete_run();
   end
endmodule
